// file: rtl/scc_defs.svh
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

`define SCC_PW_CHARS 12
`define SCC_PW_BITS 96
`define SCC_PW_LEN_W 4
`define SCC_CNT_W 32
`define SCC_POINT_W 16
`define SCC_SRE_USED 8'h38
`define SCC_SRE_CLEAR 8'h00
`define SCC_RQS_BIT 6
`define SCC_INIT_CYC 3'h4
`define SCC_CHR_A 8'h41
`define SCC_CHR_Z 8'h5a
`define SCC_CHR_0 8'h30
`define SCC_CHR_9 8'h39
`define SCC_RES_GOOD 32'h0000_0000
`define SCC_RES_FAIL 32'h0000_0001
`define SCC_GROUP_STEPS 8'h04

`endif

// file: rtl/scc_pkg.sv
`include "scc_defs.svh"

package scc_pkg;

	typedef enum logic [3:0] {
		SCC_OP_PSC_SET = 4'h0,
		SCC_OP_PSC_Q = 4'h1,
		SCC_OP_SRE_SET = 4'h2,
		SCC_OP_SRE_Q = 4'h3,
		SCC_OP_STB_Q = 4'h4,
		SCC_OP_CAL_EXEC = 4'h5,
		SCC_OP_COUNT_Q = 4'h6,
		SCC_OP_CAL_STORE = 4'h7,
		SCC_OP_PW_SET = 4'h8,
		SCC_OP_LOCK_SET = 4'h9,
		SCC_OP_LOCK_Q = 4'ha,
		SCC_OP_POINT_SEL = 4'hb
	} scc_op_t;

	typedef struct packed {
		scc_op_t op;
		logic [`SCC_POINT_W-1:0] arg;
		logic [`SCC_PW_LEN_W-1:0] pw_len;
		logic [`SCC_PW_BITS-1:0] pw;
	} scc_cmd_t;

	typedef struct packed {
		logic err;
		logic [`SCC_CNT_W-1:0] data;
	} scc_rsp_t;

	typedef struct packed {
		logic psc;
		logic locked;
		logic [7:0] sre;
		logic [`SCC_CNT_W-1:0] count;
		logic [`SCC_PW_LEN_W-1:0] pw_len;
		logic [`SCC_PW_BITS-1:0] pw;
	} scc_nv_t;

	typedef enum logic [2:0] {
		SCC_ST_INIT = 3'b001,
		SCC_ST_IDLE = 3'b010,
		SCC_ST_CAL = 3'b100
	} scc_state_t;

	typedef enum logic [2:0] {
		SCC_CS_IDLE = 3'b001,
		SCC_CS_REQ = 3'b010,
		SCC_CS_WAIT = 3'b100
	} scc_cal_state_t;

endpackage

// file: rtl/scc_cal_seq.sv
`timescale 1ns/1ps
`include "scc_defs.svh"

module scc_cal_seq #(
	parameter logic [7:0] GROUP_STEPS = `SCC_GROUP_STEPS
) (
	input wire logic sys_clk_i, // system clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic ce_i, // clock enable
	input wire logic start_i, // start pulse
	input wire logic single_i, // one step only
	input wire logic step_done_i, // adjust engine finished a step
	input wire logic step_fail_i, // step failed, with done
	output logic step_req_o, // step request pulse
	output logic point_o, // one point performed, pulse
	output logic done_o, // sequence finished, pulse
	output logic fail_o // outcome of last sequence
);
	scc_pkg::scc_cal_state_t st_q, st_d;
	logic [7:0] left_q, left_d;
	logic step_req_d, point_d, done_d, fail_d;

	wire last_step = (left_q == 8'h01) || step_fail_i;

	always_comb begin
		st_d = st_q;
		left_d = left_q;
		step_req_d = 1'b0;
		point_d = 1'b0;
		done_d = 1'b0;
		fail_d = fail_o;
		unique case (st_q)
			scc_pkg::SCC_CS_IDLE: begin
				if (start_i) begin
					left_d = single_i ? 8'h01 : GROUP_STEPS;
					fail_d = 1'b0;
					step_req_d = 1'b1;
					st_d = scc_pkg::SCC_CS_REQ;
				end
			end
			scc_pkg::SCC_CS_REQ: begin
				st_d = scc_pkg::SCC_CS_WAIT;
			end
			scc_pkg::SCC_CS_WAIT: begin
				if (step_done_i) begin
					point_d = 1'b1;
					left_d = left_q - 8'h01;
					if (last_step) begin
						fail_d = step_fail_i;
						done_d = 1'b1;
						st_d = scc_pkg::SCC_CS_IDLE;
					end else begin
						step_req_d = 1'b1;
						st_d = scc_pkg::SCC_CS_REQ;
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= scc_pkg::SCC_CS_IDLE;
			left_q <= 8'h00;
			step_req_o <= 1'b0;
			point_o <= 1'b0;
			done_o <= 1'b0;
			fail_o <= 1'b0;
		end else if (ce_i) begin
			st_q <= st_d;
			left_q <= left_d;
			step_req_o <= step_req_d;
			point_o <= point_d;
			done_o <= done_d;
			fail_o <= fail_d;
		end
	end
endmodule

// file: rtl/scc_top.sv
// Overview of operation
// - At power-up both enable masks are cleared when the non-volatile power-on clear setting is set.
// - The power-on clear setting is 0 to keep the masks and 1 to clear them, and nothing else is accepted.
// - The power-on clear query answers 0 when clearing is off and 1 when it is on.
// - The service request enable mask is 8 bits, each write replaces all of it, and only bits 3 to 5 act.
// - The service request enable query returns the whole mask as a number.
// - The status byte query answers like a serial poll and never clears the request bit.
// - Calibrate-execute adjusts with the selected calibration point and runs only while unsecured.
// - Calibrate-execute with 1 runs one step and with 0 runs the whole group of the selected mode.
// - Calibrate-execute answers 0 on success and 1 on failure.
// - A non-volatile counter adds one per calibration point and is read by the count query.
// - The counter wraps to zero after its maximum instead of saturating.
// - The store command commits every calibration value changed since the last store.
// - A new password is accepted only after calibration was unsecured with the old password.
// - A password is 1 to 12 characters, each a capital letter or a digit.
// - No command reads the password back, and a factory default password can be restored.
// - Lock state off with the right password unsecures, on secures, the query gives 1 for secured, and it persists.
`timescale 1ns/1ps
`include "scc_defs.svh"

module scc_top #(
	parameter logic [7:0] GROUP_STEPS = `SCC_GROUP_STEPS,
	parameter logic [`SCC_PW_LEN_W-1:0] FACTORY_PW_LEN = 4'h6,
	parameter logic [`SCC_PW_BITS-1:0] FACTORY_PW = 96'h0000_0000_0000_3132_5a59_5851 // arbitrary value
) (
	input wire logic sys_clk_i, // 125 MHz system clock
	input wire logic rst_b_i, // async reset, active low
	input wire logic ce_i, // clock enable
	input wire logic cmd_valid_i, // command present
	input wire scc_pkg::scc_cmd_t cmd_i, // decoded command
	output logic cmd_ready_o, // command can be taken
	output logic rsp_valid_o, // reply pulse
	output scc_pkg::scc_rsp_t rsp_o, // reply value and refusal
	input wire logic [7:0] stb_summary_i, // status summary bits
	output logic srq_o, // service request level
	output logic [7:0] sre_o, // service request enable mask
	output logic ese_clear_o, // clear event enable mask, pulse
	input wire scc_pkg::scc_nv_t nv_i, // stored state at power-up
	output scc_pkg::scc_nv_t nv_o, // state to keep stored
	output logic nv_commit_o, // commit changed cal values, pulse
	input wire logic pw_factory_pin_i, // factory password jumper
	output logic [`SCC_POINT_W-1:0] cal_point_o, // selected mode and range
	output logic cal_step_req_o, // adjust one step, pulse
	input wire logic cal_step_done_i, // adjust step finished
	input wire logic cal_step_fail_i // adjust step failed
);
	scc_pkg::scc_state_t st_q, st_d;
	logic [2:0] init_q;
	logic fac_s1_q, fac_s2_q, fac_s3_q, fac_q;
	logic psc_q, locked_q, dirty_q;
	logic [7:0] sre_q;
	logic [`SCC_CNT_W-1:0] count_q;
	logic [`SCC_PW_LEN_W-1:0] pw_len_q;
	logic [`SCC_PW_BITS-1:0] pw_q;
	logic [`SCC_POINT_W-1:0] point_q;
	logic srq_q, ese_clr_q, commit_q, ready_q, rsp_v_q;
	scc_pkg::scc_rsp_t rsp_q;
	logic [`SCC_PW_CHARS-1:0] chr_good;
	logic [`SCC_PW_BITS-1:0] pw_m;
	logic seq_point, seq_done, seq_fail;

	function automatic logic chr_ok(input logic [7:0] c);
		chr_ok = ((c >= `SCC_CHR_A) && (c <= `SCC_CHR_Z)) || ((c >= `SCC_CHR_0) && (c <= `SCC_CHR_9));
	endfunction

	// unused character slots are zeroed so comparison ignores them
	genvar gi;
	generate
		for (gi = 0; gi < `SCC_PW_CHARS; gi++) begin : g_chr
			wire in_len = (gi < cmd_i.pw_len);
			assign chr_good[gi] = !in_len || chr_ok(cmd_i.pw[gi*8 +: 8]);
			assign pw_m[gi*8 +: 8] = in_len ? cmd_i.pw[gi*8 +: 8] : 8'h00;
		end
	endgenerate

	wire pw_len_ok = (cmd_i.pw_len != 4'h0) && (cmd_i.pw_len <= 4'(`SCC_PW_CHARS));
	wire pw_form_ok = pw_len_ok && (&chr_good);
	wire pw_match = pw_form_ok && (cmd_i.pw_len == pw_len_q) && (pw_m == pw_q);

	wire take = ce_i && cmd_valid_i && ready_q && (st_q == scc_pkg::SCC_ST_IDLE);
	wire is_psc_set = take && (cmd_i.op == scc_pkg::SCC_OP_PSC_SET);
	wire is_sre_set = take && (cmd_i.op == scc_pkg::SCC_OP_SRE_SET);
	wire is_cal = take && (cmd_i.op == scc_pkg::SCC_OP_CAL_EXEC);
	wire is_store = take && (cmd_i.op == scc_pkg::SCC_OP_CAL_STORE);
	wire is_pw_set = take && (cmd_i.op == scc_pkg::SCC_OP_PW_SET);
	wire is_lock = take && (cmd_i.op == scc_pkg::SCC_OP_LOCK_SET);
	wire is_point = take && (cmd_i.op == scc_pkg::SCC_OP_POINT_SEL);

	wire arg_bool_ok = (cmd_i.arg[`SCC_POINT_W-1:1] == '0);
	wire cal_start = is_cal && !locked_q && arg_bool_ok;
	wire pw_accept = is_pw_set && !locked_q && pw_form_ok;
	wire unlock_ok = is_lock && arg_bool_ok && !cmd_i.arg[0] && pw_match;
	wire lock_on = is_lock && arg_bool_ok && cmd_i.arg[0];
	wire init_fire = (st_q == scc_pkg::SCC_ST_INIT) && (init_q == 3'h0);

	// request summary bit follows bits 3..5 of status and mask only
	wire rqs = |(stb_summary_i & sre_q & `SCC_SRE_USED);
	wire [7:0] stb_val = {stb_summary_i[7], rqs, stb_summary_i[`SCC_RQS_BIT-1:0]};
	wire fac_stable = (fac_s2_q == fac_s3_q);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			scc_pkg::SCC_ST_INIT: begin
				if (init_q == 3'h0) begin
					st_d = scc_pkg::SCC_ST_IDLE;
				end
			end
			scc_pkg::SCC_ST_IDLE: begin
				if (cal_start) begin
					st_d = scc_pkg::SCC_ST_CAL;
				end
			end
			scc_pkg::SCC_ST_CAL: begin
				if (seq_done) begin
					st_d = scc_pkg::SCC_ST_IDLE;
				end
			end
		endcase
	end

	// reply to each taken command
	scc_pkg::scc_rsp_t rsp_d;
	logic rsp_v_d;
	always_comb begin
		rsp_d = '0;
		rsp_v_d = take && !cal_start;
		if (st_q == scc_pkg::SCC_ST_CAL) begin
			rsp_v_d = seq_done;
			rsp_d.data = seq_fail ? `SCC_RES_FAIL : `SCC_RES_GOOD;
		end else begin
			unique case (cmd_i.op)
				scc_pkg::SCC_OP_PSC_SET: rsp_d.err = !arg_bool_ok;
				scc_pkg::SCC_OP_PSC_Q: rsp_d.data = 32'(psc_q);
				scc_pkg::SCC_OP_SRE_SET: rsp_d.err = (cmd_i.arg[`SCC_POINT_W-1:8] != '0);
				scc_pkg::SCC_OP_SRE_Q: rsp_d.data = 32'(sre_q);
				scc_pkg::SCC_OP_STB_Q: rsp_d.data = 32'(stb_val);
				scc_pkg::SCC_OP_CAL_EXEC: rsp_d.err = 1'b1;
				scc_pkg::SCC_OP_COUNT_Q: rsp_d.data = count_q;
				scc_pkg::SCC_OP_CAL_STORE: rsp_d.err = 1'b0;
				scc_pkg::SCC_OP_PW_SET: rsp_d.err = !pw_accept;
				scc_pkg::SCC_OP_LOCK_SET: rsp_d.err = !(unlock_ok || lock_on);
				scc_pkg::SCC_OP_LOCK_Q: rsp_d.data = 32'(locked_q);
				scc_pkg::SCC_OP_POINT_SEL: rsp_d.err = 1'b0;
				default: rsp_d.err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fac_s1_q <= 1'b0;
			fac_s2_q <= 1'b0;
			fac_s3_q <= 1'b0;
			fac_q <= 1'b0;
		end else if (ce_i) begin
			fac_s1_q <= pw_factory_pin_i;
			fac_s2_q <= fac_s1_q;
			fac_s3_q <= fac_s2_q;
			if (fac_stable) begin
				fac_q <= fac_s3_q;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= scc_pkg::SCC_ST_INIT;
			init_q <= `SCC_INIT_CYC;
			ready_q <= 1'b0;
			rsp_v_q <= 1'b0;
			rsp_q <= '0;
			srq_q <= 1'b0;
		end else if (ce_i) begin
			st_q <= st_d;
			if (init_q != 3'h0) begin
				init_q <= init_q - 3'h1;
			end
			ready_q <= (st_d == scc_pkg::SCC_ST_IDLE);
			rsp_v_q <= rsp_v_d;
			rsp_q <= rsp_d;
			srq_q <= rqs;
		end
	end

	// stored settings, loaded once after power-up
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			psc_q <= 1'b0;
			sre_q <= `SCC_SRE_CLEAR;
			ese_clr_q <= 1'b0;
			locked_q <= 1'b1;
			pw_len_q <= '0;
			pw_q <= '0;
		end else if (ce_i) begin
			ese_clr_q <= init_fire && nv_i.psc;
			if (init_fire) begin
				psc_q <= nv_i.psc;
				sre_q <= nv_i.psc ? `SCC_SRE_CLEAR : nv_i.sre;
				locked_q <= nv_i.locked;
				pw_len_q <= fac_q ? FACTORY_PW_LEN : nv_i.pw_len;
				pw_q <= fac_q ? FACTORY_PW : nv_i.pw;
			end
			if (is_psc_set && arg_bool_ok) begin
				psc_q <= cmd_i.arg[0];
			end
			if (is_sre_set && (cmd_i.arg[`SCC_POINT_W-1:8] == '0)) begin
				sre_q <= cmd_i.arg[7:0];
			end
			if (lock_on) begin
				locked_q <= 1'b1;
			end else if (unlock_ok) begin
				locked_q <= 1'b0;
			end
			if (pw_accept) begin
				pw_len_q <= cmd_i.pw_len;
				pw_q <= pw_m;
			end
		end
	end

	// point counter, point selection and change tracking
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			count_q <= '0;
			point_q <= '0;
			dirty_q <= 1'b0;
			commit_q <= 1'b0;
		end else if (ce_i) begin
			if (init_fire) begin
				count_q <= nv_i.count;
			end else if (seq_point) begin
				count_q <= count_q + 32'h0000_0001;
			end
			if (is_point) begin
				point_q <= cmd_i.arg;
			end
			commit_q <= is_store && dirty_q;
			// step fail is only valid with done; the sequencer holds the outcome beside its point pulse
			dirty_q <= (seq_point && !seq_fail) || (dirty_q && !is_store);
		end
	end

	scc_cal_seq #(
		.GROUP_STEPS(GROUP_STEPS)
	) u_seq (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.ce_i(ce_i),
		.start_i(cal_start),
		.single_i(cmd_i.arg[0]),
		.step_done_i(cal_step_done_i),
		.step_fail_i(cal_step_fail_i),
		.step_req_o(cal_step_req_o),
		.point_o(seq_point),
		.done_o(seq_done),
		.fail_o(seq_fail)
	);

	assign cmd_ready_o = ready_q;
	assign rsp_valid_o = rsp_v_q;
	assign rsp_o = rsp_q;
	assign srq_o = srq_q;
	assign sre_o = sre_q;
	assign ese_clear_o = ese_clr_q;
	assign nv_commit_o = commit_q;
	assign cal_point_o = point_q;
	assign nv_o = '{psc: psc_q, locked: locked_q, sre: sre_q, count: count_q, pw_len: pw_len_q, pw: pw_q};
endmodule

// file: verif/scc_top_properties.sv
`timescale 1ns/1ps
module scc_top_properties (
	input wire logic sys_clk_i, // clock
	input wire logic rst_b_i, // reset
	input wire logic ce_i, // enable
	input wire logic cmd_valid_i, // cmd valid
	input wire scc_pkg::scc_cmd_t cmd_i, // cmd
	input wire logic cmd_ready_o, // ready
	input wire logic rsp_valid_o, // reply valid
	input wire scc_pkg::scc_rsp_t rsp_o, // reply
	input wire logic [7:0] stb_summary_i, // status
	input wire logic srq_o, // request
	input wire logic [7:0] sre_o, // mask
	input wire scc_pkg::scc_nv_t nv_o, // live state
	input wire logic cal_step_req_o // step req
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence take_s(scc_pkg::scc_op_t o);
		ce_i && cmd_valid_i && cmd_ready_o && cmd_i.op == o;
	endsequence
	sequence ok_s;
		rsp_valid_o && !rsp_o.err;
	endsequence
	srq_level_a: assert property ($past(ce_i) |-> srq_o == |($past(stb_summary_i) & $past(sre_o) & 8'h38))
		else $error("srq level");
	sre_write_a: assert property (take_s(scc_pkg::SCC_OP_SRE_SET) ##0 cmd_i.arg <= 16'h00ff |=>
		ok_s ##0 sre_o == $past(cmd_i.arg[7:0])) else $error("sre write");
	sre_refuse_a: assert property (take_s(scc_pkg::SCC_OP_SRE_SET) ##0 cmd_i.arg > 16'h00ff |=>
		rsp_valid_o && rsp_o.err && $stable(sre_o)) else $error("sre refuse");
	psc_set_a: assert property (take_s(scc_pkg::SCC_OP_PSC_SET) ##0 cmd_i.arg <= 16'h0001 |=>
		ok_s ##0 nv_o.psc == $past(cmd_i.arg[0])) else $error("psc set");
	psc_query_a: assert property (take_s(scc_pkg::SCC_OP_PSC_Q) |=> ok_s ##0 rsp_o.data == {31'h0, nv_o.psc})
		else $error("psc query");
	lock_query_a: assert property (take_s(scc_pkg::SCC_OP_LOCK_Q) |=> ok_s ##0 rsp_o.data == {31'h0, nv_o.locked})
		else $error("lock query");
	count_query_a: assert property (take_s(scc_pkg::SCC_OP_COUNT_Q) |=> ok_s ##0 rsp_o.data == nv_o.count)
		else $error("count query");
	stb_query_a: assert property (take_s(scc_pkg::SCC_OP_STB_Q) |=> ok_s ##0
		rsp_o.data[5:0] == $past(stb_summary_i[5:0]) && rsp_o.data[31:8] == 24'h0) else $error("stb query");
	exec_locked_a: assert property (take_s(scc_pkg::SCC_OP_CAL_EXEC) ##0 nv_o.locked |=>
		rsp_valid_o && rsp_o.err && !cal_step_req_o) else $error("exec locked");
	exec_start_a: assert property (take_s(scc_pkg::SCC_OP_CAL_EXEC) ##0 !nv_o.locked && cmd_i.arg <= 16'h0001 |=>
		cal_step_req_o && !cmd_ready_o && !rsp_valid_o) else $error("exec start");
endmodule
bind scc_top scc_top_properties chk_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
	.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
	.rsp_o(rsp_o), .stb_summary_i(stb_summary_i), .srq_o(srq_o), .sre_o(sre_o), .nv_o(nv_o),
	.cal_step_req_o(cal_step_req_o));

// file: verif/scc_adj_model.sv
`timescale 1ns/1ps
module scc_adj_model (
	input wire logic sys_clk_i, // clock
	input wire logic step_req_i, // step request
	input wire logic [7:0] fail_at_i, // step index that fails
	output logic done_o, // step finished
	output logic fail_o // failed, valid with done
);
	logic [7:0] n_q = 8'h00;
	initial begin
		done_o = 1'b0;
		fail_o = 1'b0;
		forever begin
			@(posedge sys_clk_i);
			#2;
			if (!done_o) fail_o = ~fail_o; // meaningless outside done
		end
	end
	always @(posedge sys_clk_i) begin
		if (step_req_i) begin
			repeat ($urandom_range(3)) @(posedge sys_clk_i);
			#1;
			done_o = 1'b1;
			fail_o = (n_q == fail_at_i);
			@(posedge sys_clk_i);
			#1;
			done_o = 1'b0;
			n_q = n_q + 8'h01;
		end
	end
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic sys_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cmd_valid_i = 1'b0;
	scc_pkg::scc_cmd_t cmd_i = '0;
	scc_pkg::scc_rsp_t rsp_o;
	scc_pkg::scc_nv_t nv_i, nv_o;
	logic cmd_ready_o, rsp_valid_o, srq_o, ese_clear_o, nv_commit_o, step_req, step_done, step_fail;
	logic [7:0] stb = 8'hff;
	logic [7:0] sre_o, v;
	logic [7:0] fail_at = 8'hff;
	logic ce = 1'b1;
	logic fac_pin = 1'b1;
	logic [15:0] cal_point_o;
	scc_pkg::scc_rsp_t q[$];
	int n_mismatch = 0;
	int n_tests = 0;
	int n_ese = 0;
	int n_commit = 0;
	scc_top dut_u (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(ce), .cmd_valid_i(cmd_valid_i),
		.cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o),
		.stb_summary_i(stb), .srq_o(srq_o), .sre_o(sre_o), .ese_clear_o(ese_clear_o), .nv_i(nv_i),
		.nv_o(nv_o), .nv_commit_o(nv_commit_o), .pw_factory_pin_i(fac_pin), .cal_point_o(cal_point_o),
		.cal_step_req_o(step_req), .cal_step_done_i(step_done), .cal_step_fail_i(step_fail));
	scc_adj_model adj_u (.sys_clk_i(sys_clk_i), .step_req_i(step_req), .fail_at_i(fail_at),
		.done_o(step_done), .fail_o(step_fail));
	initial forever #4 sys_clk_i = ~sys_clk_i;
	task automatic bad(input string m);
		n_mismatch++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) bad($sformatf("got %h exp %h", got, exp));
	endtask
	// x data in a note means the value is not looked at
	task automatic chk_rsp(input scc_pkg::scc_rsp_t got, input scc_pkg::scc_rsp_t exp);
		n_tests++;
		if (got.err !== exp.err || (exp.data !== 32'hx && got.data !== exp.data)) bad($sformatf("reply %h exp %h", got, exp));
	endtask
	task automatic send(input scc_pkg::scc_op_t op, input logic [15:0] arg, input logic err, input logic [31:0] d,
			input logic [3:0] len = 4'h0, input logic [95:0] pw = 96'h0);
		int i;
		q.push_back('{err: err, data: d});
		cmd_valid_i = 1'b1;
		cmd_i = '{op: op, arg: arg, pw_len: len, pw: pw};
		for (i = 0; i < 100; i++) begin
			@(posedge sys_clk_i);
			if (cmd_ready_o === 1'b1) break;
		end
		#1;
	endtask
	task automatic idle(input string name);
		int i;
		cmd_valid_i = 1'b0;
		for (i = 0; i < 100 && q.size() > 0; i++) @(posedge sys_clk_i);
		if (q.size() > 0) bad("reply missing");
		repeat (2) @(posedge sys_clk_i);
		#1;
		$display("test %s done", name);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		if (rsp_valid_o === 1'b1) begin
			if (q.size() == 0) bad("unexpected reply");
			else chk_rsp(rsp_o, q.pop_front());
		end
		if (ese_clear_o === 1'b1) n_ese++;
		if (nv_commit_o === 1'b1) n_commit++;
	end
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		void'($urandom(28338));
		nv_i = '{psc: 1'b1, locked: 1'b1, sre: 8'hff, count: 32'hffff_fffe, pw_len: 4'h0, pw: 96'h0};
		repeat (8) @(posedge sys_clk_i);
		#1;
		rst_b_i = 1'b1;
		repeat (8) @(posedge sys_clk_i);
		#1;
		chk({24'h0, sre_o}, 32'h0);
		chk(32'(n_ese), 32'h1);
		send(scc_pkg::SCC_OP_PSC_Q, 16'h0, 1'b0, 32'h1);
		send(scc_pkg::SCC_OP_LOCK_Q, 16'h0, 1'b0, 32'h1);
		send(scc_pkg::SCC_OP_COUNT_Q, 16'h0, 1'b0, 32'hffff_fffe);
		idle("power_up");
		v = 8'($urandom_range(255));
		stb = 8'($urandom);
		send(scc_pkg::SCC_OP_SRE_SET, {8'h0, v}, 1'b0, 'x);
		send(scc_pkg::SCC_OP_SRE_Q, 16'h0, 1'b0, {24'h0, v});
		send(scc_pkg::SCC_OP_SRE_SET, 16'h0100, 1'b1, 'x);
		send(scc_pkg::SCC_OP_SRE_Q, 16'h0, 1'b0, {24'h0, v});
		idle("sre");
		// a write offered while the clock enable is low must not be taken
		ce = 1'b0;
		cmd_valid_i = 1'b1;
		cmd_i = '{op: scc_pkg::SCC_OP_SRE_SET, arg: {8'h0, ~v}, pw_len: 4'h0, pw: 96'h0};
		repeat (4) @(posedge sys_clk_i);
		#1;
		chk({24'h0, sre_o}, {24'h0, v});
		ce = 1'b1;
		send(scc_pkg::SCC_OP_STB_Q, 16'h0, 1'b0, {24'h0, stb[7], |(stb & v & 8'h38), stb[5:0]});
		send(scc_pkg::SCC_OP_STB_Q, 16'h0, 1'b0, {24'h0, stb[7], |(stb & v & 8'h38), stb[5:0]});
		send(scc_pkg::SCC_OP_PSC_SET, 16'h0, 1'b0, 'x);
		send(scc_pkg::SCC_OP_PSC_SET, 16'h2, 1'b1, 'x);
		send(scc_pkg::SCC_OP_PSC_Q, 16'h0, 1'b0, 32'h0);
		idle("stb_psc");
		send(scc_pkg::SCC_OP_CAL_EXEC, 16'h1, 1'b1, 'x);
		send(scc_pkg::SCC_OP_PW_SET, 16'h0, 1'b1, 'x, 4'h3, 96'h394241);
		send(scc_pkg::SCC_OP_LOCK_SET, 16'h0, 1'b1, 'x, 4'h1, 96'h41);
		send(scc_pkg::SCC_OP_LOCK_SET, 16'h0, 1'b0, 'x, 4'h6, 96'h3132_5a59_5851);
		send(scc_pkg::SCC_OP_LOCK_Q, 16'h0, 1'b0, 32'h0);
		send(scc_pkg::SCC_OP_PW_SET, 16'h0, 1'b1, 'x, 4'h1, 96'h61);
		send(scc_pkg::SCC_OP_PW_SET, 16'h0, 1'b1, 'x, 4'hd, 96'h41);
		send(scc_pkg::SCC_OP_PW_SET, 16'h0, 1'b0, 'x, 4'h3, 96'h394241);
		send(scc_pkg::SCC_OP_LOCK_SET, 16'h1, 1'b0, 'x);
		send(scc_pkg::SCC_OP_LOCK_SET, 16'h0, 1'b1, 'x, 4'h6, 96'h3132_5a59_5851);
		send(scc_pkg::SCC_OP_LOCK_SET, 16'h0, 1'b0, 'x, 4'h3, 96'h394241);
		idle("security");
		send(scc_pkg::SCC_OP_POINT_SEL, {v, v}, 1'b0, 'x);
		send(scc_pkg::SCC_OP_CAL_EXEC, 16'h1, 1'b0, 32'h0);
		send(scc_pkg::SCC_OP_CAL_STORE, 16'h0, 1'b0, 'x);
		send(scc_pkg::SCC_OP_COUNT_Q, 16'h0, 1'b0, 32'hffff_ffff);
		send(scc_pkg::SCC_OP_CAL_EXEC, 16'h0, 1'b0, 32'h0);
		send(scc_pkg::SCC_OP_COUNT_Q, 16'h0, 1'b0, 32'h3);
		fail_at = 8'h06;
		send(scc_pkg::SCC_OP_CAL_EXEC, 16'h0, 1'b0, 32'h1);
		send(scc_pkg::SCC_OP_COUNT_Q, 16'h0, 1'b0, 32'h5);
		send(scc_pkg::SCC_OP_CAL_EXEC, 16'h2, 1'b1, 'x);
		idle("calibrate");
		chk({16'h0, cal_point_o}, {16'h0, v, v});
		send(scc_pkg::SCC_OP_CAL_STORE, 16'h0, 1'b0, 'x);
		send(scc_pkg::SCC_OP_CAL_STORE, 16'h0, 1'b0, 'x);
		idle("store");
		chk(32'(n_commit), 32'h2);
		// second power-up: masks kept, stored password used with the jumper open
		rst_b_i = 1'b0;
		fac_pin = 1'b0;
		nv_i = '{psc: 1'b0, locked: 1'b1, sre: 8'h28, count: 32'h0000_0007, pw_len: 4'h2, pw: 96'h3742};
		repeat (3) @(posedge sys_clk_i);
		#1;
		n_ese = 0;
		rst_b_i = 1'b1;
		repeat (8) @(posedge sys_clk_i);
		#1;
		chk({24'h0, sre_o}, 32'h0000_0028);
		chk(32'(n_ese), 32'h0);
		send(scc_pkg::SCC_OP_PSC_Q, 16'h0, 1'b0, 32'h0);
		send(scc_pkg::SCC_OP_COUNT_Q, 16'h0, 1'b0, 32'h7);
		send(scc_pkg::SCC_OP_LOCK_Q, 16'h0, 1'b0, 32'h1);
		send(scc_pkg::SCC_OP_LOCK_SET, 16'h0, 1'b1, 'x, 4'h6, 96'h3132_5a59_5851);
		send(scc_pkg::SCC_OP_LOCK_SET, 16'h0, 1'b0, 'x, 4'h2, 96'h3742);
		send(scc_pkg::SCC_OP_LOCK_Q, 16'h0, 1'b0, 32'h0);
		idle("power_up_stored");
		report_and_stop();
	end
endmodule
